// [verilog/rss_sequencer.sv]
// Purpose: reset cause decode, master clear filter, power-up and
//          oscillator start-up delay sequencing
// Assumes: 10 MHz clock; power-on and brown-out arrive as pulses/levels
// Notes:   timers run on edge enables from rc_osc_tick_i and clock_input_pin_i
`timescale 1ns/1ps
module rss_sequencer (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // pins and analog events
  input  wire logic       master_clear_pin_n_i,
  input  wire logic       power_on_pulse_i,
  input  wire logic       brownout_reset_i,
  input  wire logic       clock_input_pin_i,
  input  wire logic       rc_osc_tick_i,
  // core side
  input  wire logic       watchdog_timer_expire_i,
  input  wire logic       sleep_req_i,
  input  wire logic       wake_irq_i,
  // configuration
  input  wire logic       power_up_timer_en_i,
  input  wire logic       brownout_en_i,
  input  wire logic [1:0] oscillator_select_bits_i,
  // status
  output logic            core_reset_o,
  output logic            wake_resume_o,
  output logic            timeout_flag_o,
  output logic            powerdown_flag_o,
  output logic [2:0]      cause_o,
  output logic            sleeping_o,
  output logic            master_clear_oe_o
);
  typedef struct packed {
    logic [1:0]         rst_sync;
    logic [1:0]         mc_sync;
    logic [1:0]         ck_sync;
    logic [1:0]         rc_sync;
    logic               ck_prev;
    logic               rc_prev;
    logic [4:0]         filt_cnt;
    logic               mc_low;
    logic [19:0]        power_up_timer_cnt;
    logic [10:0]        ost_cnt;
    rss_pkg::rss_state_t st;
    logic               core_rst;
    logic               wake;
    logic               to_f;
    logic               pd_f;
    logic [2:0]         cause;
  } rss_reg_t;
  rss_reg_t s_r, s_nxt;
  logic     rst_n;
  assign rst_n = s_r.rst_sync[1];

  function automatic logic is_crystal(input logic [1:0] sel);
    is_crystal = (sel != rss_pkg::OSC_RC);
  endfunction : is_crystal

  // ==========================================================
  // next state
  always_comb begin
    logic ck_edge;
    logic rc_tick;
    logic mc_fire;
    logic power_up_timer_on;
    ck_edge = 1'b0;
    rc_tick = 1'b0;
    mc_fire = 1'b0;
    power_up_timer_on = 1'b0;
    s_nxt = s_r;
    s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
    s_nxt.mc_sync  = {s_r.mc_sync[0], master_clear_pin_n_i};
    s_nxt.ck_sync  = {s_r.ck_sync[0], clock_input_pin_i};
    s_nxt.rc_sync  = {s_r.rc_sync[0], rc_osc_tick_i};
    s_nxt.ck_prev  = s_r.ck_sync[1];
    s_nxt.rc_prev  = s_r.rc_sync[1];
    ck_edge = s_r.ck_sync[1] & ~s_r.ck_prev;
    rc_tick = s_r.rc_sync[1] & ~s_r.rc_prev;
    s_nxt.wake = 1'b0;
    // glitch filter: low must persist FILT_CYC + 1 cycles
    if (s_r.mc_sync[1]) begin
      s_nxt.filt_cnt = '0;
      s_nxt.mc_low   = 1'b0;
    end else if (s_r.filt_cnt == rss_pkg::FILT_CYC_W) begin
      s_nxt.mc_low = 1'b1;
    end else begin
      s_nxt.filt_cnt = s_r.filt_cnt + 5'h01;
    end
    mc_fire = s_nxt.mc_low & ~s_r.mc_low;
    power_up_timer_on = ~power_up_timer_en_i | brownout_en_i;
    if (power_on_pulse_i) begin
      s_nxt.cause = rss_pkg::CAUSE_POR;
      s_nxt.to_f  = rss_pkg::FLAG_RST;
      s_nxt.pd_f  = rss_pkg::FLAG_RST;
      s_nxt.st    = rss_pkg::ST_HOLD;
      s_nxt.core_rst = 1'b1;
    end else if (brownout_en_i && brownout_reset_i) begin
      s_nxt.cause = rss_pkg::CAUSE_BOR;
      s_nxt.to_f  = 1'b1;
      s_nxt.pd_f  = 1'b1;
      s_nxt.st    = rss_pkg::ST_HOLD;
      s_nxt.core_rst = 1'b1;
    end else if (s_nxt.mc_low) begin
      s_nxt.core_rst = 1'b1;
      if (mc_fire && s_r.st == rss_pkg::ST_SLP) begin
        s_nxt.cause = rss_pkg::CAUSE_MC_SLP;
        s_nxt.to_f  = 1'b1;
        s_nxt.pd_f  = 1'b0;
      end else if (mc_fire && s_r.st == rss_pkg::ST_RUN) begin
        s_nxt.cause = rss_pkg::CAUSE_MC_RUN;
      end
      if (s_r.st == rss_pkg::ST_RUN || s_r.st == rss_pkg::ST_SLP)
        s_nxt.st = rss_pkg::ST_RUN;
    end else begin
      case (s_r.st)
        rss_pkg::ST_HOLD: begin
          s_nxt.power_up_timer_cnt = '0;
          s_nxt.ost_cnt  = '0;
          // power-up delay only after power-on or brownout
          if (power_up_timer_on && (s_r.cause == rss_pkg::CAUSE_POR ||
                          s_r.cause == rss_pkg::CAUSE_BOR))
            s_nxt.st = rss_pkg::ST_POWER_UP_TIMER;
          else if (is_crystal(oscillator_select_bits_i) &&
                   s_r.cause == rss_pkg::CAUSE_POR)
            s_nxt.st = rss_pkg::ST_OST;
          else begin
            s_nxt.st = rss_pkg::ST_RUN;
            s_nxt.core_rst = 1'b0;
          end
        end
        rss_pkg::ST_POWER_UP_TIMER: begin
          s_nxt.core_rst = 1'b1;
          if (rc_tick) s_nxt.power_up_timer_cnt = s_r.power_up_timer_cnt + 20'h00001;
          if (s_r.power_up_timer_cnt ==
              20'(rss_pkg::POWER_UP_TIMER_CYC / rss_pkg::RC_DIV)) begin
            if (is_crystal(oscillator_select_bits_i))
              s_nxt.st = rss_pkg::ST_OST;
            else begin
              s_nxt.st = rss_pkg::ST_RUN;
              s_nxt.core_rst = 1'b0;
            end
          end
        end
        rss_pkg::ST_OST: begin
          if (ck_edge) begin
            s_nxt.ost_cnt = s_r.ost_cnt + 11'h001;
            if (s_r.ost_cnt == rss_pkg::OST_LAST) begin
              s_nxt.st = s_r.core_rst ? rss_pkg::ST_RUN
                                      : rss_pkg::ST_RUN;
              if (!s_r.core_rst) s_nxt.wake = 1'b1;
              s_nxt.core_rst = 1'b0;
            end
          end
        end
        rss_pkg::ST_RUN: begin
          s_nxt.core_rst = 1'b0;
          if (watchdog_timer_expire_i) begin
            s_nxt.cause = rss_pkg::CAUSE_WD_RST;
            s_nxt.to_f  = 1'b0;
            s_nxt.pd_f  = 1'b1;
            s_nxt.core_rst = 1'b1;
            s_nxt.st    = rss_pkg::ST_HOLD;
          end else if (sleep_req_i) begin
            s_nxt.st   = rss_pkg::ST_SLP;
            s_nxt.pd_f = 1'b0;
            s_nxt.to_f = 1'b1;
          end
        end
        rss_pkg::ST_SLP: begin
          if (watchdog_timer_expire_i || wake_irq_i) begin
            if (watchdog_timer_expire_i) begin
              s_nxt.cause = rss_pkg::CAUSE_WD_WAK;
              s_nxt.to_f  = 1'b0;
            end
            s_nxt.ost_cnt = '0;
            if (is_crystal(oscillator_select_bits_i))
              s_nxt.st = rss_pkg::ST_OST;
            else begin
              s_nxt.st   = rss_pkg::ST_RUN;
              s_nxt.wake = 1'b1;
            end
          end
        end
        default: s_nxt.st = rss_pkg::ST_HOLD;
      endcase
    end
  end

  // ==========================================================
  // state register; power-on defaults
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.st <= rss_pkg::ST_HOLD;
      s_r.core_rst <= 1'b1;
      s_r.to_f <= 1'b1;
      s_r.pd_f <= 1'b1;
      s_r.mc_sync <= 2'h3;
    end else if (!rst_n) begin
      s_r.rst_sync <= s_nxt.rst_sync;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops; pin never driven
  assign core_reset_o      = s_r.core_rst;
  assign wake_resume_o     = s_r.wake;
  assign timeout_flag_o    = s_r.to_f;
  assign powerdown_flag_o  = s_r.pd_f;
  assign cause_o           = s_r.cause;
  assign sleeping_o        = s_r.st[4];
  assign master_clear_oe_o = s_r.rst_sync[1] & 1'b0;

  // ==========================================================
  // checks
  wd_no_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !master_clear_oe_o) else $error("pin driven");
  power_up_timer_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    s_r.st == rss_pkg::ST_POWER_UP_TIMER |-> core_reset_o)
    else $error("reset dropped in power_up_timer");
  release_ost_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(s_r.st) == rss_pkg::ST_OST && s_r.st == rss_pkg::ST_RUN
    |-> $past(s_r.ost_cnt) == rss_pkg::OST_LAST)
    else $error("early start-up release");
  rc_no_ost_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    oscillator_select_bits_i == rss_pkg::OSC_RC &&
    s_r.st != rss_pkg::ST_OST |=> s_r.st != rss_pkg::ST_OST)
    else $error("start-up in rc");
  por_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    power_on_pulse_i |=> timeout_flag_o && powerdown_flag_o &&
    cause_o == rss_pkg::CAUSE_POR) else $error("por flags");
  wake_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    wake_resume_o |-> !core_reset_o)
    else $error("wake reset core");
  short_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(s_r.mc_low) |-> !s_r.mc_sync[1][*3])
    else $error("short pulse taken");
  wdt_rst_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    s_r.st == rss_pkg::ST_RUN && watchdog_timer_expire_i && !s_nxt.mc_low &&
    !power_on_pulse_i && !(brownout_en_i && brownout_reset_i)
    |=> core_reset_o && !timeout_flag_o) else $error("wdt reset");
endmodule : rss_sequencer

// [verilog/rss_pkg.sv]
// Purpose: constants and types for the reset and start-up sequencer
// Assumes: 10 MHz reference clock
// Notes:   FILT_CYC derived from FILT_NS; other counts given directly
package rss_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ         = 10000000;
  localparam int unsigned POWER_UP_TIMER_MS        = 72;
  localparam int unsigned POWER_UP_TIMER_CYC       = 720000; // 72 ms at 10 MHz
  localparam int unsigned OST_CYCLES     = 1024;
  localparam int unsigned FILT_NS        = 500;
  localparam int unsigned FILT_CYC       = (FILT_NS * (CLK_HZ / 1000000))
                                           / 1000;
  localparam int unsigned RC_DIV         = 16; // internal rc tick divider
  localparam logic [4:0]  FILT_CYC_W     = 5'(FILT_CYC);
  localparam logic [3:0]  RC_DIV_LAST    = 4'(RC_DIV - 1);
  localparam logic [10:0] OST_LAST       = 11'(OST_CYCLES - 1);
  // ==========================================================
  // oscillator select encodings
  localparam logic [1:0] OSC_RC  = 2'h3;
  localparam logic [1:0] OSC_HS  = 2'h2;
  localparam logic [1:0] OSC_XT  = 2'h1;
  localparam logic [1:0] OSC_LP  = 2'h0;
  // ==========================================================
  // reset cause codes
  typedef enum logic [2:0] {
    CAUSE_POR    = 3'h0,
    CAUSE_MC_RUN = 3'h1,
    CAUSE_MC_SLP = 3'h2,
    CAUSE_WD_RST = 3'h3,
    CAUSE_WD_WAK = 3'h4,
    CAUSE_BOR    = 3'h5
  } rss_cause_t;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_POWER_UP_TIMER = 5'h02,
    ST_OST  = 5'h04,
    ST_RUN  = 5'h08,
    ST_SLP  = 5'h10
  } rss_state_t;
  localparam logic FLAG_RST = 1'b1;
endpackage : rss_pkg

// [testbench/rss_far_side.sv]
// Purpose: far side model: crystal or driven clock, reset pin driver
// Assumes: half period counted in reference clock cycles
// Notes:   pin has a pull-up, so released means high, never stale
`timescale 1ns/1ps
module rss_far_side (
  // control from bench
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] half_i,
  input  wire logic       hold_low_i,
  // pins
  output logic            clock_input_pin_o,
  output logic            master_clear_pin_n_o
);
  logic [2:0] cnt_r = 3'h0;
  logic       ck_r  = 1'b0;
  // ==========================================================
  // oscillator: crystal in any mode, or a driven clock in hs mode
  assign clock_input_pin_o = ck_r;
  always @(posedge ref_clk_i) begin
    #10;
    if (cnt_r + 3'h1 >= half_i) begin
      cnt_r = 3'h0;
      ck_r = ~ck_r;
    end else begin
      cnt_r = cnt_r + 3'h1;
    end
  end
  // ==========================================================
  // reset driver holds the pin low until conditions are met
  assign master_clear_pin_n_o = hold_low_i ? 1'b0 : 1'b1;
endmodule : rss_far_side

// [testbench/reset_startup_sequencer_tb_top.sv]
// Purpose: self-checking bench for the reset and start-up sequencer
// Assumes: rc tick toggles each cycle, crystal half period one cycle
// Notes:   the power-up delay is long, so it is met only once
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module reset_startup_sequencer_tb_top;
  // ==========================================================
  // stimulus, observed outputs and model state
  logic       ref_clk = 1'b0;
  logic       resetn, por, bor, bor_en, wdt, slp, wak, power_up_timer_dis;
  logic       rc = 1'b0;
  logic       mc_hold, clk_in, mc_n;
  logic [1:0] osc;
  logic       core_rst, wake_res, to_f, pd_f, slp_o, mc_oe;
  logic [2:0] cause;
  int         err_count, check_count, cyc, n, sw, m_to, m_pd;
  bit         seen;
  int         to_tab[6] = '{1, -1, 1, 0, 0, 1};
  int         pd_tab[6] = '{1, -1, 0, 1, 0, 1};
  rss_sequencer u_rss_sequencer (
    .ref_clk_i(ref_clk), .resetn_i(resetn),
    .master_clear_pin_n_i(mc_n), .power_on_pulse_i(por),
    .brownout_reset_i(bor), .clock_input_pin_i(clk_in),
    .rc_osc_tick_i(rc), .watchdog_timer_expire_i(wdt),
    .sleep_req_i(slp), .wake_irq_i(wak),
    .power_up_timer_en_i(power_up_timer_dis), .brownout_en_i(bor_en),
    .oscillator_select_bits_i(osc), .core_reset_o(core_rst),
    .wake_resume_o(wake_res), .timeout_flag_o(to_f),
    .powerdown_flag_o(pd_f), .cause_o(cause), .sleeping_o(slp_o),
    .master_clear_oe_o(mc_oe));
  rss_far_side u_far (.ref_clk_i(ref_clk), .half_i(3'h1),
    .hold_low_i(mc_hold), .clock_input_pin_o(clk_in),
    .master_clear_pin_n_o(mc_n));
  // ==========================================================
  // clocks and hang guard; rc tick made on the edge, race free
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) rc <= ~rc;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 110000) begin
      err_count++;
      summarize();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #10;
  endtask : tick
  // model: nominal hold time, crystal half period of one cycle
  function automatic int exp_len(input logic [1:0] m, input bit pw);
    return (m != rss_pkg::OSC_RC ? 2 * int'(rss_pkg::OST_CYCLES) : 0) +
           (pw ? 2 * int'(rss_pkg::POWER_UP_TIMER_CYC / rss_pkg::RC_DIV) : 0);
  endfunction : exp_len
  task automatic win(input int e);
    `CHK("delay window", 1'b1, 1'(n >= e - 20 && n <= e + 80))
  endtask : win
  task automatic wait_for(input bit wake);
    n = 0;
    seen = 1'b0;
    while (n < 100000 && (wake ? wake_res !== 1'b1 : core_rst !== 1'b0))
    begin
      tick(1);
      n++;
      seen |= (core_rst === 1'b1);
    end
  endtask : wait_for
  task automatic expect_cause(input logic [2:0] c);
    if (to_tab[c] >= 0) m_to = to_tab[c];
    if (pd_tab[c] >= 0) m_pd = pd_tab[c];
    `CHK("cause", c, cause)
    `CHK("timeout flag", 1'(m_to), to_f)
    `CHK("powerdown flag", 1'(m_pd), pd_f)
  endtask : expect_cause
  task automatic go_sleep(input logic [1:0] m);
    osc = m;
    slp = 1'b1;
    tick(1);
    slp = 1'b0;
    tick(2);
    m_to = 1;
    m_pd = 0;
    `CHK("sleeping", 1'b1, slp_o)
    `CHK("sleep flags", 2'b10, {to_f, pd_f})
  endtask : go_sleep
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // main sequence
  initial begin
    {resetn, por, bor, bor_en, wdt, slp, wak, mc_hold} = 8'h00;
    power_up_timer_dis = 1'b1;
    osc = rss_pkg::OSC_LP;
    sw = $urandom(59787);
    tick(4);
    resetn = 1'b1;
    tick(3);
    // power-on in every mode, power-up delay off
    for (int i = 0; i < 4; i++) begin
      osc = 2'(i);
      por = 1'b1;
      tick(1);
      por = 1'b0;
      `CHK("reset held", 1'b1, core_rst)
      expect_cause(rss_pkg::CAUSE_POR);
      wait_for(1'b0);
      win(exp_len(2'(i), 1'b0));
    end
    // power-up delay on from here: other causes must not start it
    power_up_timer_dis = 1'b0;
    // short glitch on the pin is swallowed
    sw = 1 + $urandom % 4;
    mc_hold = 1'b1;
    tick(sw);
    mc_hold = 1'b0;
    tick(12);
    `CHK("glitch", 1'b0, core_rst)
    // pin reset in run, then watchdog reset
    mc_hold = 1'b1;
    tick(12);
    `CHK("pin reset", 1'b1, core_rst)
    expect_cause(rss_pkg::CAUSE_MC_RUN);
    mc_hold = 1'b0;
    wait_for(1'b0);
    win(0);
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    `CHK("wd reset", 1'b1, core_rst)
    `CHK("pin drive", 1'b0, mc_oe)
    expect_cause(rss_pkg::CAUSE_WD_RST);
    wait_for(1'b0);
    win(0);
    // watchdog wake in crystal mode waits for the start-up count
    go_sleep(rss_pkg::OSC_XT);
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    wait_for(1'b1);
    `CHK("wake no reset", 1'b0, seen)
    win(exp_len(rss_pkg::OSC_XT, 1'b0));
    expect_cause(rss_pkg::CAUSE_WD_WAK);
    // interrupt wake in rc mode skips it
    go_sleep(rss_pkg::OSC_RC);
    wak = 1'b1;
    tick(1);
    wak = 1'b0;
    wait_for(1'b1);
    win(0);
    `CHK("irq wake flags", 2'b10, {to_f, pd_f})
    // pin reset during sleep
    go_sleep(rss_pkg::OSC_XT);
    mc_hold = 1'b1;
    tick(12);
    expect_cause(rss_pkg::CAUSE_MC_SLP);
    mc_hold = 1'b0;
    wait_for(1'b0);
    win(0);
    // brownout: ignored while disabled, then forces power-up delay
    bor = 1'b1;
    osc = rss_pkg::OSC_RC;
    tick(10);
    `CHK("bor disabled", 1'b0, core_rst)
    por = 1'b1;
    tick(1);
    por = 1'b0;
    tick(300);
    `CHK("power-up delay", 1'b1, core_rst)
    expect_cause(rss_pkg::CAUSE_POR);
    bor_en = 1'b1;
    tick(2);
    bor = 1'b0;
    expect_cause(rss_pkg::CAUSE_BOR);
    wait_for(1'b0);
    win(exp_len(rss_pkg::OSC_RC, 1'b1));
    summarize();
  end
endmodule : reset_startup_sequencer_tb_top
